// file: psm_ctrl.sv
// Power saving mode controller with classic Wishbone register slave
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module psm_ctrl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [4:0] ext_pin_i,
  input wire logic kbd_change_i,
  input wire logic wdt_event_i,
  input wire logic irq_any_i,
  input wire logic ext_data_move_i,
  output logic cpu_clk_en_o,
  output logic periph_clk_en_o,
  output logic sys_clk_en_o,
  output logic wake_reset_o,
  output logic [6:0] wake_src_o,
  output logic wake_vector_req_o,
  output logic flash_write_en_o
);
  ////////////////////////////////////////////////////////////////////////////
  logic [5:0] pin_sync;
  logic [5:0] pin_prev_ff;
  logic [5:0] nxt_pin_prev;
  psm_sync #(.W(6)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({kbd_change_i, ext_pin_i}),
    .q_o(pin_sync)
  );
  always_comb begin
    nxt_pin_prev = pin_sync;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_prev_ff <= '0;
    end else begin
      pin_prev_ff <= nxt_pin_prev;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] pwr_ctrl_ff;
  logic [7:0] wake_en_ff;
  logic [1:0] key_ff;
  logic ack_ff;
  logic [31:0] dat_ff;
  psm_pkg::psm_mode_e mode_ff;
  logic cpu_clk_ff;
  logic periph_clk_ff;
  logic sys_clk_ff;
  logic wake_rst_ff;
  logic [6:0] wake_src_ff;
  logic vec_ff;
  logic flash_we_ff;
  logic [7:0] nxt_pwr_ctrl;
  logic [7:0] nxt_wake_en;
  logic [1:0] nxt_key;
  logic nxt_ack;
  logic [31:0] nxt_dat;
  psm_pkg::psm_mode_e nxt_mode;
  logic nxt_cpu_clk;
  logic nxt_periph_clk;
  logic nxt_sys_clk;
  logic nxt_wake_rst;
  logic [6:0] nxt_wake_src;
  logic nxt_vec;
  logic nxt_flash_we;
  logic req;
  logic wr_lane0;
  logic [5:0] pin_edge;
  logic [6:0] stop_wake;
  logic stop_any;
  logic idle_any;

  // Rising-edge detection on synchronised pins, gated by enables for stop wake only
  always_comb begin
    req = cyc_i && stb_i && !ack_ff;
    wr_lane0 = req && we_i && sel_i[0];
    pin_edge = pin_sync & ~pin_prev_ff;
    stop_wake[4:0] = pin_edge[4:0] & wake_en_ff[4:0];
    stop_wake[5] = pin_edge[5] & wake_en_ff[psm_pkg::BIT_KB_WAKE];
    stop_wake[6] = wdt_event_i & wake_en_ff[psm_pkg::BIT_WD_WAKE];
    stop_any = |stop_wake;
    idle_any = |pin_edge | wdt_event_i | irq_any_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_pwr_ctrl = pwr_ctrl_ff;
    nxt_wake_en = wake_en_ff;
    nxt_key = key_ff;
    nxt_ack = req;
    nxt_dat = dat_ff;
    nxt_mode = mode_ff;
    nxt_wake_rst = 1'b0;
    nxt_vec = 1'b0;
    nxt_wake_src = wake_src_ff;
    if (req && !we_i) begin
      case (adr_i)
        psm_pkg::ADDR_PWR_CTRL: nxt_dat = {24'h00_0000, pwr_ctrl_ff};
        psm_pkg::ADDR_WAKE_EN: nxt_dat = {24'h00_0000, wake_en_ff};
        psm_pkg::ADDR_STATUS: nxt_dat = {16'h0000, 1'b0, wake_src_ff, 5'h00, mode_ff};
        default: nxt_dat = 32'h0000_0000;
      endcase
    end
    if (wr_lane0) begin
      if (adr_i == psm_pkg::ADDR_PWR_CTRL) begin
        nxt_pwr_ctrl = dat_i[7:0];
        nxt_key = 2'b00;
      end else if (adr_i == psm_pkg::ADDR_WAKE_EN) begin
        if (key_ff == 2'b10) begin
          nxt_wake_en = dat_i[7:0] & psm_pkg::WAKE_EN_MASK;
          nxt_key = 2'b00;
        end else if (dat_i[7:0] == psm_pkg::KEY_FIRST) begin
          nxt_key = 2'b01;
        end else if (key_ff == 2'b01 && dat_i[7:0] == psm_pkg::KEY_SECOND) begin
          nxt_key = 2'b10;
        end else begin
          nxt_key = 2'b00;
        end
      end else begin
        nxt_key = 2'b00;
      end
    end
    case (mode_ff)
      psm_pkg::PSM_RUN: begin
        if (nxt_pwr_ctrl[psm_pkg::BIT_STOP]) begin
          nxt_mode = psm_pkg::PSM_STOP;
        end else if (nxt_pwr_ctrl[psm_pkg::BIT_IDLE]) begin
          nxt_mode = psm_pkg::PSM_IDLE;
        end
      end
      psm_pkg::PSM_IDLE: begin
        if (idle_any) begin
          nxt_mode = psm_pkg::PSM_RUN;
          nxt_pwr_ctrl[psm_pkg::BIT_IDLE] = 1'b0;
          nxt_pwr_ctrl[psm_pkg::BIT_STOP] = 1'b0;
          nxt_wake_src = {wdt_event_i, pin_edge};
        end
      end
      psm_pkg::PSM_STOP: begin
        if (stop_any) begin
          nxt_mode = psm_pkg::PSM_RUN;
          nxt_pwr_ctrl[psm_pkg::BIT_IDLE] = 1'b0;
          nxt_pwr_ctrl[psm_pkg::BIT_STOP] = 1'b0;
          nxt_wake_src = stop_wake;
          nxt_wake_rst = pwr_ctrl_ff[psm_pkg::BIT_STOP_RST];
          nxt_vec = !pwr_ctrl_ff[psm_pkg::BIT_STOP_RST];
        end
      end
      default: nxt_mode = psm_pkg::PSM_RUN;
    endcase
    nxt_cpu_clk = (nxt_mode == psm_pkg::PSM_RUN);
    nxt_periph_clk = (nxt_mode != psm_pkg::PSM_STOP);
    nxt_sys_clk = (nxt_mode != psm_pkg::PSM_STOP);
    nxt_flash_we = ext_data_move_i && pwr_ctrl_ff[psm_pkg::BIT_PWE];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr_ctrl_ff <= psm_pkg::RST_PWR_CTRL;
      wake_en_ff <= psm_pkg::RST_WAKE_EN;
      key_ff <= 2'b00;
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
      mode_ff <= psm_pkg::PSM_RUN;
      cpu_clk_ff <= 1'b1;
      periph_clk_ff <= 1'b1;
      sys_clk_ff <= 1'b1;
      wake_rst_ff <= 1'b0;
      wake_src_ff <= 7'h00;
      vec_ff <= 1'b0;
      flash_we_ff <= 1'b0;
    end else begin
      pwr_ctrl_ff <= nxt_pwr_ctrl;
      wake_en_ff <= nxt_wake_en;
      key_ff <= nxt_key;
      ack_ff <= nxt_ack;
      dat_ff <= nxt_dat;
      mode_ff <= nxt_mode;
      cpu_clk_ff <= nxt_cpu_clk;
      periph_clk_ff <= nxt_periph_clk;
      sys_clk_ff <= nxt_sys_clk;
      wake_rst_ff <= nxt_wake_rst;
      wake_src_ff <= nxt_wake_src;
      vec_ff <= nxt_vec;
      flash_we_ff <= nxt_flash_we;
    end
  end

  assign dat_o = dat_ff;
  assign ack_o = ack_ff;
  assign cpu_clk_en_o = cpu_clk_ff;
  assign periph_clk_en_o = periph_clk_ff;
  assign sys_clk_en_o = sys_clk_ff;
  assign wake_reset_o = wake_rst_ff;
  assign wake_src_o = wake_src_ff;
  assign wake_vector_req_o = vec_ff;
  assign flash_write_en_o = flash_we_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  // Armed one edge after reset, so no sampled history reaches before it
  logic chk_armed_ff;
  logic nxt_chk_armed;
  always_comb begin
    nxt_chk_armed = 1'b1;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chk_armed_ff <= 1'b0;
    end else begin
      chk_armed_ff <= nxt_chk_armed;
    end
  end

  sequence s_stop_entry;
    mode_ff == psm_pkg::PSM_RUN && nxt_pwr_ctrl[psm_pkg::BIT_STOP];
  endsequence
  sequence s_stop_wake;
    mode_ff == psm_pkg::PSM_STOP && stop_any;
  endsequence
  sequence s_idle_wake;
    mode_ff == psm_pkg::PSM_IDLE && idle_any;
  endsequence

  AST_IDLE_GATE: assert property (@(posedge clk_i) disable iff (rst_i || !chk_armed_ff)
    (mode_ff == psm_pkg::PSM_IDLE) |-> ##1 (!cpu_clk_en_o || $past(idle_any)))
    else $error("cpu clock not gated in idle");
  AST_IDLE_PERIPH: assert property (@(posedge clk_i) disable iff (rst_i || !chk_armed_ff)
    $past(mode_ff == psm_pkg::PSM_IDLE) |-> periph_clk_en_o)
    else $error("peripheral clock stopped in idle");
  AST_STOP_CLK: assert property (@(posedge clk_i) disable iff (rst_i || !chk_armed_ff)
    s_stop_entry |-> ##1 (!sys_clk_en_o && !periph_clk_en_o))
    else $error("clocks still running after stop entry");
  AST_STOP_PERIPH: assert property (@(posedge clk_i) disable iff (rst_i || !chk_armed_ff)
    (mode_ff == psm_pkg::PSM_STOP) |-> !periph_clk_en_o)
    else $error("peripheral clock running in stop");
  AST_STOP_CPU: assert property (@(posedge clk_i) disable iff (rst_i || !chk_armed_ff)
    (mode_ff == psm_pkg::PSM_STOP) |-> !cpu_clk_en_o)
    else $error("cpu clock running in stop");
  AST_WAKE_ENABLE: assert property (@(posedge clk_i) disable iff (rst_i || !chk_armed_ff)
    (mode_ff == psm_pkg::PSM_STOP && !stop_any) |=> (mode_ff == psm_pkg::PSM_STOP))
    else $error("stop left without enabled source");
  AST_WAKE_SRC: assert property (@(posedge clk_i) disable iff (rst_i || !chk_armed_ff)
    s_stop_wake |=> (wake_src_o == $past(stop_wake) && mode_ff == psm_pkg::PSM_RUN))
    else $error("wake source not reported after stop wakeup");
  AST_KB_GATE: assert property (@(posedge clk_i) disable iff (rst_i || !chk_armed_ff)
    !wake_en_ff[psm_pkg::BIT_KB_WAKE] |-> !stop_wake[psm_pkg::NUM_EXT])
    else $error("keyboard wake passed while disabled");
  AST_WAKE_RST: assert property (@(posedge clk_i) disable iff (rst_i || !chk_armed_ff)
    s_stop_wake |=> (wake_reset_o == $past(pwr_ctrl_ff[psm_pkg::BIT_STOP_RST])
      && wake_vector_req_o != wake_reset_o))
    else $error("wrong stop wakeup action");
  AST_IDLE_EXIT: assert property (@(posedge clk_i) disable iff (rst_i || !chk_armed_ff)
    (mode_ff == psm_pkg::PSM_IDLE && irq_any_i) |=> (cpu_clk_en_o && !wake_reset_o))
    else $error("idle not exited on interrupt");
  AST_FLASH_WE: assert property (@(posedge clk_i) disable iff (rst_i || !chk_armed_ff)
    flash_write_en_o |-> $past(pwr_ctrl_ff[psm_pkg::BIT_PWE] && ext_data_move_i))
    else $error("flash write without enable");
  AST_RSVD: assert property (@(posedge clk_i) disable iff (rst_i || !chk_armed_ff)
    (wake_en_ff & ~psm_pkg::WAKE_EN_MASK) == 8'h00)
    else $error("reserved wake bit set");
  AST_KEY: assert property (@(posedge clk_i) disable iff (rst_i || !chk_armed_ff)
    $changed(wake_en_ff) |-> $past(key_ff) == 2'b10)
    else $error("wake enable changed without keys");
  AST_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i || !chk_armed_ff)
    s_stop_wake |=> !pwr_ctrl_ff[psm_pkg::BIT_STOP] && !pwr_ctrl_ff[psm_pkg::BIT_IDLE])
    else $error("mode bits not cleared on wakeup");
  AST_IDLE_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i || !chk_armed_ff)
    s_idle_wake |=> (mode_ff == psm_pkg::PSM_RUN && !pwr_ctrl_ff[psm_pkg::BIT_IDLE]))
    else $error("idle bit not cleared on wakeup");
  AST_STOP_RESUME: assert property (@(posedge clk_i) disable iff (rst_i || !chk_armed_ff)
    s_stop_wake |=> (sys_clk_en_o && periph_clk_en_o && cpu_clk_en_o))
    else $error("clocks not restored after stop wakeup");
endmodule // psm_ctrl
`default_nettype wire

// file: psm_pkg.sv
// Package: constants for the power saving mode controller
package psm_pkg;
  localparam logic [7:0] ADDR_PWR_CTRL = 8'h87;
  localparam logic [7:0] ADDR_WAKE_EN = 8'hb6;
  localparam logic [7:0] ADDR_STATUS = 8'hc4;
  localparam logic [7:0] RST_PWR_CTRL = 8'h00;
  localparam logic [7:0] RST_WAKE_EN = 8'h9f;
  localparam logic [7:0] WAKE_EN_MASK = 8'hdf;
  localparam logic [7:0] KEY_FIRST = 8'haf;
  localparam logic [7:0] KEY_SECOND = 8'h50;
  localparam int BIT_STOP = 1;
  localparam int BIT_STOP_RST = 3;
  localparam int BIT_PWE = 4;
  localparam int BIT_IDLE = 5;
  localparam int BIT_WD_WAKE = 6;
  localparam int BIT_KB_WAKE = 7;
  localparam int NUM_EXT = 5;
  typedef enum logic [2:0] {
    PSM_RUN = 3'b001,
    PSM_IDLE = 3'b010,
    PSM_STOP = 3'b100
  } psm_mode_e;
endpackage

// file: psm_sync.sv
// Two-flop synchroniser for asynchronous wake pins
`timescale 1ns/1ps
`default_nettype none
module psm_sync #(
  parameter int W = 6
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_sync;
  always_comb begin
    nxt_meta = d_i;
    nxt_sync = meta_ff;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end
  assign q_o = sync_ff;
endmodule // psm_sync
`default_nettype wire

// file: psm_wake_model.sv
// Wake source model: external pins, keyboard change and watchdog
`timescale 1ns/1ps
`default_nettype none
module psm_wake_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [6:0] fire_i,
  output logic [4:0] ext_pin_o,
  output logic kbd_change_o,
  output logic wdt_event_o
);
  logic [6:0] lvl_ff;
  logic [2:0] hold_ff;
  ////////////////////////////////////////////////////////////////////
  // Pins rise and stay high a few cycles, watchdog is one clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lvl_ff <= 7'h00;
      hold_ff <= 3'h0;
    end else if (fire_i != 7'h00) begin
      lvl_ff <= fire_i;
      hold_ff <= 3'h4;
    end else if (hold_ff != 3'h0) begin
      hold_ff <= hold_ff - 3'h1;
    end else begin
      lvl_ff <= 7'h00;
    end
  end
  assign ext_pin_o = lvl_ff[4:0];
  assign kbd_change_o = lvl_ff[5];
  assign wdt_event_o = lvl_ff[6] && (hold_ff == 3'h4);
endmodule // psm_wake_model
`default_nettype wire

// file: psm_ctrl_tb.sv
// Self-checking testbench for the power saving mode controller
`timescale 1ns/1ps
`default_nettype none
module psm_ctrl_tb;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, irq = 0, mov = 0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0000_0000;
  logic [6:0] fire = 7'h00;
  logic [3:0] sel = 4'h0;
  wire logic [31:0] dat_o;
  wire logic [4:0] pin;
  wire logic [6:0] wsrc;
  wire logic ack, kbd, wdt, cpu_en, per_en, sys_en, wrst, wvec, fwe;
  int miscompares = 0, check_count = 0, cycles = 0, n_rst = 0, n_vec = 0;
  logic [7:0] rd;
  logic [7:0] rd_hi;
  psm_ctrl u_psm_ctrl (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack), .ext_pin_i(pin),
    .kbd_change_i(kbd), .wdt_event_i(wdt), .irq_any_i(irq), .ext_data_move_i(mov),
    .cpu_clk_en_o(cpu_en), .periph_clk_en_o(per_en), .sys_clk_en_o(sys_en),
    .wake_reset_o(wrst), .wake_src_o(wsrc), .wake_vector_req_o(wvec), .flash_write_en_o(fwe));
  psm_wake_model u_psm_wake_model (.clk_i(clk_i), .rst_i(rst_i), .fire_i(fire),
    .ext_pin_o(pin), .kbd_change_o(kbd), .wdt_event_o(wdt));
  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (wrst === 1'b1) n_rst++;
    if (wvec === 1'b1) n_vec++;
    if (cycles == 3000) begin
      miscompares++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic results();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'h1;
    adr <= a;
    dat <= {24'h00_0000, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = dat_o[7:0];
    rd_hi = dat_o[15:8];
    cyc <= 1'b0;
    stb <= 1'b0;
    sel <= 4'h0;
  endtask
  task automatic keyw(input logic [7:0] d);
    wb(1, psm_pkg::ADDR_WAKE_EN, psm_pkg::KEY_FIRST);
    wb(1, psm_pkg::ADDR_WAKE_EN, psm_pkg::KEY_SECOND);
    wb(1, psm_pkg::ADDR_WAKE_EN, d);
  endtask
  task automatic fire_src(input logic [6:0] f);
    @(posedge clk_i);
    fire <= f;
    @(posedge clk_i);
    fire <= 7'h00;
    repeat (10) @(posedge clk_i);
  endtask
  ////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    wb(0, psm_pkg::ADDR_PWR_CTRL, 8'h00);
    chk("power_control", rd, 8'h00);
    wb(0, psm_pkg::ADDR_WAKE_EN, 8'h00);
    chk("wakeup_enable", rd, 8'h9f);
    wb(0, 8'h55, 8'h00);
    chk("unmapped", rd, 8'h00);
    chk("clocks", {cpu_en, per_en, sys_en}, 8'h07);
  endtask
  task automatic t_idle();
    wb(1, psm_pkg::ADDR_PWR_CTRL, 8'h20);
    repeat (2) @(posedge clk_i);
    chk("idle cpu", cpu_en, 8'h00);
    chk("idle periph", per_en, 8'h01);
    wb(0, psm_pkg::ADDR_STATUS, 8'h00);
    chk("status idle", rd, 8'h02);
    irq <= 1'b1;
    @(posedge clk_i);
    irq <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("idle exit", {cpu_en, wrst}, 8'h02);
    wb(0, psm_pkg::ADDR_PWR_CTRL, 8'h00);
    chk("idle clear", rd, 8'h00);
  endtask
  task automatic t_stop_next();
    wb(1, psm_pkg::ADDR_PWR_CTRL, 8'h02);
    repeat (2) @(posedge clk_i);
    chk("stop clocks", {cpu_en, per_en, sys_en}, 8'h00);
    fire_src(7'h40);
    chk("wdt masked", sys_en, 8'h00);
    fire_src(7'h01);
    chk("pin wake", {sys_en, wsrc}, 8'h81);
    chk("vector req", n_vec[7:0], 8'h01);
    chk("no reset", n_rst[7:0], 8'h00);
    wb(0, psm_pkg::ADDR_STATUS, 8'h00);
    chk("status run", rd, 8'h01);
    chk("status source", rd_hi, 8'h01);
    wb(0, psm_pkg::ADDR_PWR_CTRL, 8'h00);
    chk("stop clear", rd, 8'h00);
  endtask
  task automatic t_stop_reset();
    keyw(8'hff);
    wb(0, psm_pkg::ADDR_WAKE_EN, 8'h00);
    chk("reserved bit", rd, 8'hdf);
    wb(1, psm_pkg::ADDR_WAKE_EN, 8'h40);
    wb(0, psm_pkg::ADDR_WAKE_EN, 8'h00);
    chk("no key", rd, 8'hdf);
    keyw(8'h40);
    wb(1, psm_pkg::ADDR_PWR_CTRL, 8'h0a);
    wb(0, psm_pkg::ADDR_STATUS, 8'h00);
    chk("status stop", rd, 8'h04);
    fire_src(7'h20);
    chk("kbd masked", sys_en, 8'h00);
    fire_src(7'h02);
    chk("pin masked", sys_en, 8'h00);
    fire_src(7'h40);
    chk("wdt wake", {sys_en, wsrc}, 8'hc0);
    chk("reset req", n_rst[7:0], 8'h01);
    chk("vector idle", n_vec[7:0], 8'h01);
  endtask
  task automatic t_flash();
    wb(1, psm_pkg::ADDR_PWR_CTRL, 8'h10);
    mov <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("flash on", fwe, 8'h01);
    wb(1, psm_pkg::ADDR_PWR_CTRL, 8'h00);
    repeat (2) @(posedge clk_i);
    chk("flash off", fwe, 8'h00);
    mov <= 1'b0;
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_idle();
    t_stop_next();
    t_stop_reset();
    t_flash();
    results();
  end
endmodule // psm_ctrl_tb
`default_nettype wire
